/* rtl/usr_shift_regs.vh */
// Constants for the universal shift/storage register block:
// register offsets, field positions, reset values and mode codes.
// Assumes a 4-bit AXI4-Lite byte address window, one word per register.
`ifndef USR_SHIFT_REGS_VH
`define USR_SHIFT_REGS_VH

// Register byte offsets
`define USR_OFF_STATE      4'h0
`define USR_OFF_STATUS     4'h4
`define USR_OFF_OPCOUNT    4'h8
`define USR_OFF_COUNT_CTRL 4'hc

// Mode codes, {mode_select_hi, mode_select_lo}
`define USR_MODE_HOLD  2'b00
`define USR_MODE_RIGHT 2'b01
`define USR_MODE_LEFT  2'b10
`define USR_MODE_LOAD  2'b11

// Status register field positions
`define USR_ST_MODE_LO_BIT 0
`define USR_ST_MODE_HI_BIT 1
`define USR_ST_CLEAR_BIT   2
`define USR_ST_DRIVE_BIT   3
`define USR_ST_OEA_N_BIT   4
`define USR_ST_OEB_N_BIT   5

// Count control field positions, width and reset value
`define USR_CC_EN_BIT    0
`define USR_CC_LOAD_BIT  1
`define USR_CC_SHIFT_BIT 2
`define USR_CC_CLEAR_BIT 3
`define USR_CC_W         4
`define USR_CC_RESET     4'he

// Operation counter reset value
`define USR_OPCOUNT_RESET 32'h00000000

// Idle level of {out_enable_b_n, out_enable_a_n, sync_clear_n} pins
`define USR_PIN_IDLE 3'h7

// AXI response codes
`define USR_RESP_OKAY   2'b00
`define USR_RESP_SLVERR 2'b10

`endif

/* rtl/usr_sync2.v */
// Two-flip-flop synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; bits are not kept coherent.
`timescale 1ns/1ns

module usr_sync2 #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_clock,
  input  wire         i_rst,
  // Pin levels in, synchronised levels out
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] stage_a;
  reg [W-1:0] stage_b;

  // First stage feeds only the second stage
  always @(posedge i_clock) begin
    if (i_rst) begin
      stage_a <= RST_VAL;
      stage_b <= RST_VAL;
    end else begin
      stage_a <= i_async;
      stage_b <= stage_a;
    end
  end

  assign o_sync = stage_b;

endmodule // usr_sync2

/* rtl/usr_shift_register.v */
// Eight-bit universal shift/storage register with common parallel I/O,
// serial end outputs and an AXI4-Lite status and counter port.
// Assumes all pins are asynchronous to i_clock and arrive through two
// flip-flops; the host shares the parallel bus and must honour contention.
`timescale 1ns/1ns
`include "usr_shift_regs.vh"

// Behaviour
// - The block keeps an eight-bit state, bits 0 to 7, in flip-flops and can hold, shift right, shift left, load and clear it.
// - The state changes only at a rising clock edge.
// - A low clear input overrides both selects and zeroes all bits at the next edge.
// - With clear high, selects 11 load, lo-only shifts right, hi-only shifts left and 00 holds.
// - In load mode bit n takes the level of parallel pin n.
// - In right shift bit 0 takes the right serial input and bit n takes old bit n-1.
// - In left shift bit 7 takes the left serial input and bit n takes old bit n+1.
// - In hold mode every bit keeps its value.
// - With outputs enabled each stored bit is driven onto its parallel pin.
// - A high level on either active-low enable floats all parallel pins.
// - Operations still run while the parallel pins float.
// - Load mode turns the pin drivers off whatever the enables say.
// - Bits 0 and 7 are always driven on their own serial output pins.
module usr_shift_register #(
  parameter WIDTH  = 8,
  parameter ADDR_W = 4
) (
  // Clock and reset
  input  wire              i_clock,
  input  wire              i_rst,
  // Mode, clear and serial pins
  input  wire              i_mode_select_lo,
  input  wire              i_mode_select_hi,
  input  wire              i_sync_clear_n,
  input  wire              i_right_shift_serial_in,
  input  wire              i_left_shift_serial_in,
  // Output enable pins
  input  wire              i_out_enable_a_n,
  input  wire              i_out_enable_b_n,
  // Parallel two-way bus
  input  wire [WIDTH-1:0]  i_parallel_bidir_bus,
  output wire [WIDTH-1:0]  o_parallel_bidir_bus,
  output wire [WIDTH-1:0]  o_parallel_bidir_bus_oe,
  // Serial end outputs
  output wire              o_low_end_serial_out,
  output wire              o_high_end_serial_out,
  // AXI4-Lite write address
  input  wire              i_s_axi_awvalid,
  output wire              o_s_axi_awready,
  input  wire [ADDR_W-1:0] i_s_axi_awaddr,
  // AXI4-Lite write data
  input  wire              i_s_axi_wvalid,
  output wire              o_s_axi_wready,
  input  wire [31:0]       i_s_axi_wdata,
  input  wire [3:0]        i_s_axi_wstrb,
  // AXI4-Lite write response
  output wire              o_s_axi_bvalid,
  input  wire              i_s_axi_bready,
  output wire [1:0]        o_s_axi_bresp,
  // AXI4-Lite read address
  input  wire              i_s_axi_arvalid,
  output wire              o_s_axi_arready,
  input  wire [ADDR_W-1:0] i_s_axi_araddr,
  // AXI4-Lite read data
  output wire              o_s_axi_rvalid,
  input  wire              i_s_axi_rready,
  output wire [31:0]       o_s_axi_rdata,
  output wire [1:0]        o_s_axi_rresp
);

  localparam SYNC_W = WIDTH + 7;

  // One-hot write channel states
  localparam [1:0] WR_IDLE = 2'b01;
  localparam [1:0] WR_RESP = 2'b10;
  // One-hot read channel states
  localparam [1:0] RD_IDLE = 2'b01;
  localparam [1:0] RD_DATA = 2'b10;

  // Synchronised pins
  wire [SYNC_W-1:0] pins_sync;
  wire [WIDTH-1:0]  bus_in;
  wire              ser_right;
  wire              ser_left;
  wire [1:0]        mode;
  wire              clear_n;
  wire              oe_a_n;
  wire              oe_b_n;

  // Shift core
  reg  [WIDTH-1:0]  state;
  reg  [WIDTH-1:0]  next_state;
  reg               drive;
  wire              next_drive;

  // Operation counter
  reg  [31:0]         opcount;
  reg  [`USR_CC_W-1:0] count_ctrl;
  reg                  count_hit;

  // AXI write side
  reg  [1:0]        wr_fsm;
  reg               aw_got;
  reg               w_got;
  reg  [ADDR_W-1:0] wr_addr;
  reg  [31:0]       wr_data;
  reg  [3:0]        wr_strb;
  reg  [1:0]        bresp;
  wire              aw_hs;
  wire              w_hs;
  wire              aw_have;
  wire              w_have;
  wire [ADDR_W-1:0] cur_waddr;
  wire [31:0]       cur_wdata;
  wire [3:0]        cur_wstrb;
  wire              wr_fire;

  // AXI read side
  reg  [1:0]        rd_fsm;
  reg  [31:0]       rdata;
  reg  [1:0]        rresp;
  reg  [31:0]       status_word;
  wire              ar_hs;

  // Replaces the byte lanes selected by a strobe
  function [31:0] apply_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      k;
    begin
      apply_strb = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          apply_strb[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // True for the four mapped word addresses
  function is_mapped;
    input [ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `USR_OFF_STATE) ||
                  (addr == `USR_OFF_STATUS) ||
                  (addr == `USR_OFF_OPCOUNT) ||
                  (addr == `USR_OFF_COUNT_CTRL);
    end
  endfunction

  // All pins pass two flops together so a load sees the selects and the
  // bus data of the same sample; this costs two cycles of latency.
  usr_sync2 #(
    .W       (SYNC_W),
    .RST_VAL ({`USR_PIN_IDLE, {(WIDTH+4){1'b0}}})
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_out_enable_b_n, i_out_enable_a_n, i_sync_clear_n,
               i_mode_select_hi, i_mode_select_lo,
               i_left_shift_serial_in, i_right_shift_serial_in,
               i_parallel_bidir_bus}),
    .o_sync  (pins_sync)
  );

  // Unpack the synchronised sample
  assign bus_in    = pins_sync[WIDTH-1:0];
  assign ser_right = pins_sync[WIDTH];
  assign ser_left  = pins_sync[WIDTH+1];
  assign mode      = pins_sync[WIDTH+3:WIDTH+2];
  assign clear_n   = pins_sync[WIDTH+4];
  assign oe_a_n    = pins_sync[WIDTH+5];
  assign oe_b_n    = pins_sync[WIDTH+6];

  // Next value of the stored word; enables play no part here
  always @* begin
    next_state = state;
    if (!clear_n) begin
      next_state = {WIDTH{1'b0}};
    end else begin
      case (mode)
        `USR_MODE_LOAD: begin
          next_state = bus_in;
        end
        `USR_MODE_RIGHT: begin
          next_state = {state[WIDTH-2:0], ser_right};
        end
        `USR_MODE_LEFT: begin
          next_state = {ser_left, state[WIDTH-1:1]};
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // Stored word changes only on the rising edge
  always @(posedge i_clock) begin
    if (i_rst) begin
      state <= {WIDTH{1'b0}};
    end else begin
      state <= next_state;
    end
  end

  // Drivers on only with both enables low and not loading
  // The host must wait out the pin latency before driving
  assign next_drive = !oe_a_n && !oe_b_n && (mode != `USR_MODE_LOAD);

  always @(posedge i_clock) begin
    if (i_rst) begin
      drive <= 1'b0;
    end else begin
      drive <= next_drive;
    end
  end

  // Stored bits go out on the shared bus while enabled
  assign o_parallel_bidir_bus    = state;
  assign o_parallel_bidir_bus_oe = {WIDTH{drive}};

  // End bits are always driven for cascading
  assign o_low_end_serial_out  = state[0];
  assign o_high_end_serial_out = state[WIDTH-1];

  // Which clocked operation the counter should see this edge
  always @* begin
    count_hit = 1'b0;
    if (!clear_n) begin
      count_hit = count_ctrl[`USR_CC_CLEAR_BIT];
    end else if (mode == `USR_MODE_LOAD) begin
      count_hit = count_ctrl[`USR_CC_LOAD_BIT];
    end else if (mode != `USR_MODE_HOLD) begin
      count_hit = count_ctrl[`USR_CC_SHIFT_BIT];
    end
  end

  // AXI write handshakes; address and data may come in either order
  assign aw_hs     = i_s_axi_awvalid && o_s_axi_awready;
  assign w_hs      = i_s_axi_wvalid && o_s_axi_wready;
  assign aw_have   = aw_got || aw_hs;
  assign w_have    = w_got || w_hs;
  assign cur_waddr = aw_got ? wr_addr : i_s_axi_awaddr;
  assign cur_wdata = w_got ? wr_data : i_s_axi_wdata;
  assign cur_wstrb = w_got ? wr_strb : i_s_axi_wstrb;
  assign wr_fire   = (wr_fsm == WR_IDLE) && aw_have && w_have;

  assign o_s_axi_awready = (wr_fsm == WR_IDLE) && !aw_got;
  assign o_s_axi_wready  = (wr_fsm == WR_IDLE) && !w_got;
  assign o_s_axi_bvalid  = (wr_fsm == WR_RESP);
  assign o_s_axi_bresp   = bresp;

  // Write channel sequencing and capture
  always @(posedge i_clock) begin
    if (i_rst) begin
      wr_fsm  <= WR_IDLE;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bresp   <= `USR_RESP_OKAY;
    end else begin
      case (wr_fsm)
        WR_IDLE: begin
          if (wr_fire) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            bresp  <= is_mapped(cur_waddr) ? `USR_RESP_OKAY
                                           : `USR_RESP_SLVERR;
            wr_fsm <= WR_RESP;
          end else begin
            if (aw_hs) begin
              aw_got  <= 1'b1;
              wr_addr <= i_s_axi_awaddr;
            end
            if (w_hs) begin
              w_got   <= 1'b1;
              wr_data <= i_s_axi_wdata;
              wr_strb <= i_s_axi_wstrb;
            end
          end
        end
        WR_RESP: begin
          if (i_s_axi_bready) begin
            wr_fsm <= WR_IDLE;
          end
        end
        default: begin
          wr_fsm <= WR_IDLE;
        end
      endcase
    end
  end

  // Counter and its control; a software write beats a same-edge count
  always @(posedge i_clock) begin
    if (i_rst) begin
      opcount    <= `USR_OPCOUNT_RESET;
      count_ctrl <= `USR_CC_RESET;
    end else begin
      if (wr_fire && (cur_waddr == `USR_OFF_OPCOUNT)) begin
        opcount <= apply_strb(opcount, cur_wdata, cur_wstrb);
      end else if (count_ctrl[`USR_CC_EN_BIT] && count_hit) begin
        opcount <= opcount + 32'h00000001;
      end
      if (wr_fire && (cur_waddr == `USR_OFF_COUNT_CTRL) && cur_wstrb[0]) begin
        count_ctrl <= cur_wdata[`USR_CC_W-1:0];
      end
    end
  end

  // Status word gathers the synchronised pin view and driver state
  always @* begin
    status_word = 32'h00000000;
    status_word[`USR_ST_MODE_LO_BIT] = mode[0];
    status_word[`USR_ST_MODE_HI_BIT] = mode[1];
    status_word[`USR_ST_CLEAR_BIT]   = !clear_n;
    status_word[`USR_ST_DRIVE_BIT]   = drive;
    status_word[`USR_ST_OEA_N_BIT]   = oe_a_n;
    status_word[`USR_ST_OEB_N_BIT]   = oe_b_n;
  end

  // AXI read channel
  assign ar_hs           = i_s_axi_arvalid && o_s_axi_arready;
  assign o_s_axi_arready = (rd_fsm == RD_IDLE);
  assign o_s_axi_rvalid  = (rd_fsm == RD_DATA);
  assign o_s_axi_rdata   = rdata;
  assign o_s_axi_rresp   = rresp;

  // Read data is captured at the address handshake and held until taken
  always @(posedge i_clock) begin
    if (i_rst) begin
      rd_fsm <= RD_IDLE;
      rdata  <= 32'h00000000;
      rresp  <= `USR_RESP_OKAY;
    end else begin
      case (rd_fsm)
        RD_IDLE: begin
          if (ar_hs) begin
            rd_fsm <= RD_DATA;
            rresp  <= `USR_RESP_OKAY;
            case (i_s_axi_araddr)
              `USR_OFF_STATE: begin
                rdata <= {{(32-WIDTH){1'b0}}, state};
              end
              `USR_OFF_STATUS: begin
                rdata <= status_word;
              end
              `USR_OFF_OPCOUNT: begin
                rdata <= opcount;
              end
              `USR_OFF_COUNT_CTRL: begin
                rdata <= {{(32-`USR_CC_W){1'b0}}, count_ctrl};
              end
              default: begin
                rdata <= 32'h00000000;
                rresp <= `USR_RESP_SLVERR;
              end
            endcase
          end
        end
        RD_DATA: begin
          if (i_s_axi_rready) begin
            rd_fsm <= RD_IDLE;
          end
        end
        default: begin
          rd_fsm <= RD_IDLE;
        end
      endcase
    end
  end

endmodule // usr_shift_register

/* bench/usr_shift_register_chk.sv */
// Checker for pin modes, bus drivers and serial ends of the shift register.
// Assumes the two-flop pin path: a pin shows its effect three samples on.
`timescale 1ns/1ns
module usr_shift_register_chk #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire             i_clock,
  input wire             i_rst,
  // Pins in
  input wire             i_mode_select_lo,
  input wire             i_mode_select_hi,
  input wire             i_sync_clear_n,
  input wire             i_right_shift_serial_in,
  input wire             i_left_shift_serial_in,
  input wire             i_out_enable_a_n,
  input wire             i_out_enable_b_n,
  input wire [WIDTH-1:0] i_parallel_bidir_bus,
  // Pins out
  input wire [WIDTH-1:0] o_parallel_bidir_bus,
  input wire [WIDTH-1:0] o_parallel_bidir_bus_oe,
  input wire             o_low_end_serial_out,
  input wire             o_high_end_serial_out
);
  logic [1:0] settle;
  wire        ok = (settle == 2'h3);
  wire        off = i_out_enable_a_n | i_out_enable_b_n |
                    (i_mode_select_lo & i_mode_select_hi);
  // Pin history is trusted only three samples after reset
  always @(posedge i_clock) begin
    if (i_rst) settle <= 2'h0;
    else if (!ok) settle <= settle + 2'h1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Clear inactive and a given mode, as the core saw it
  sequence s_mode(logic [1:0] m);
    ok && $past(i_sync_clear_n, 3) &&
      ($past({i_mode_select_hi, i_mode_select_lo}, 3) == m);
  endsequence
  clear_zero_a: assert property (
    ok && !$past(i_sync_clear_n, 3) |-> o_parallel_bidir_bus == '0)
    else $error("clear missed");
  load_word_a: assert property (
    s_mode(2'b11) |-> o_parallel_bidir_bus == $past(i_parallel_bidir_bus, 3))
    else $error("load wrong");
  shift_right_a: assert property (
    s_mode(2'b01) |-> o_parallel_bidir_bus ==
      {$past(o_parallel_bidir_bus[WIDTH-2:0]),
       $past(i_right_shift_serial_in, 3)})
    else $error("right shift wrong");
  shift_left_a: assert property (
    s_mode(2'b10) |-> o_parallel_bidir_bus ==
      {$past(i_left_shift_serial_in, 3),
       $past(o_parallel_bidir_bus[WIDTH-1:1])})
    else $error("left shift wrong");
  hold_word_a: assert property (
    s_mode(2'b00) |-> $stable(o_parallel_bidir_bus))
    else $error("hold changed word");
  drive_off_a: assert property (
    ok && $past(off, 3) |-> o_parallel_bidir_bus_oe == '0)
    else $error("drivers left on");
  drive_on_a: assert property (
    ok && !$past(off, 3) |-> o_parallel_bidir_bus_oe == '1)
    else $error("drivers left off");
  serial_ends_a: assert property (
    o_low_end_serial_out == o_parallel_bidir_bus[0] &&
      o_high_end_serial_out == o_parallel_bidir_bus[WIDTH-1])
    else $error("serial end wrong");
endmodule // usr_shift_register_chk

bind usr_shift_register usr_shift_register_chk #(.WIDTH(WIDTH)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst),
  .i_mode_select_lo(i_mode_select_lo), .i_mode_select_hi(i_mode_select_hi),
  .i_sync_clear_n(i_sync_clear_n),
  .i_right_shift_serial_in(i_right_shift_serial_in),
  .i_left_shift_serial_in(i_left_shift_serial_in),
  .i_out_enable_a_n(i_out_enable_a_n), .i_out_enable_b_n(i_out_enable_b_n),
  .i_parallel_bidir_bus(i_parallel_bidir_bus),
  .o_parallel_bidir_bus(o_parallel_bidir_bus),
  .o_parallel_bidir_bus_oe(o_parallel_bidir_bus_oe),
  .o_low_end_serial_out(o_low_end_serial_out),
  .o_high_end_serial_out(o_high_end_serial_out));

/* bench/usr_host_model.sv */
// Host logic on the shared parallel bus; resolves the wire level.
// Assumes the bench asks to drive only around load operations.
`timescale 1ns/1ns
module usr_host_model #(
  parameter WIDTH = 8
) (
  // Clock
  input  wire              i_clock,
  // Drive request from the bench
  input  wire              i_drive_req,
  input  wire [WIDTH-1:0]  i_drive_data,
  // Device side of the bus
  input  wire [WIDTH-1:0]  i_dev_data,
  input  wire [WIDTH-1:0]  i_dev_oe,
  // Resolved wire level
  output logic [WIDTH-1:0] o_bus
);
  logic [WIDTH-1:0] last = '0;
  // Host backs off while any device driver is on, so no contention
  wire host_en = i_drive_req && (i_dev_oe == '0);
  // No pull-up: a floating wire toggles so a stale value never passes
  always @(posedge i_clock) begin
    last <= o_bus;
  end
  always @* begin
    for (int n = 0; n < WIDTH; n++)
      o_bus[n] = i_dev_oe[n] ? i_dev_data[n] :
                 host_en ? i_drive_data[n] : ~last[n];
  end
endmodule // usr_host_model

/* bench/tb_usr_shift_register.sv */
// Bench for the shift register: mode table, awkward load, register port.
// Assumes one 100 MHz clock and the host model on the parallel bus.
`timescale 1ns/1ns
`include "usr_shift_regs.vh"
module tb_usr_shift_register;
  // Row: mode, clear_n, ser_r, ser_l, {en_b_n, en_a_n}, host drive, data, exp
  typedef struct packed {
    logic [1:0] m;
    logic       c, r, l;
    logic [1:0] e;
    logic       d;
    logic [7:0] v, x;
  } usr_row_t;
  usr_row_t    rows [9] = '{24'he3a5a5, 24'h70004b, 24'ha40025, 24'ha80092,
                            24'h760025, 24'h380025, 24'hc00000, 24'h700001,
                            24'h580000};
  logic        clock, rst, lo, hi, clr_n, sr, sl, ea_n, eb_n, drv;
  logic [7:0]  drv_data;
  wire  [7:0]  bus, dev_q, dev_oe;
  wire         q0, q7, awready, wready, bvalid, arready, rvalid;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, strb;
  logic [31:0] wdata;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [1:0]  resp;
  int          miscompares, checked, n;

  usr_shift_register u_dut (
    .i_clock(clock), .i_rst(rst), .i_mode_select_lo(lo),
    .i_mode_select_hi(hi), .i_sync_clear_n(clr_n),
    .i_right_shift_serial_in(sr), .i_left_shift_serial_in(sl),
    .i_out_enable_a_n(ea_n), .i_out_enable_b_n(eb_n),
    .i_parallel_bidir_bus(bus), .o_parallel_bidir_bus(dev_q),
    .o_parallel_bidir_bus_oe(dev_oe), .o_low_end_serial_out(q0),
    .o_high_end_serial_out(q7), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(strb), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));
  usr_host_model u_host (
    .i_clock(clock), .i_drive_req(drv), .i_drive_data(drv_data),
    .i_dev_data(dev_q), .i_dev_oe(dev_oe), .o_bus(bus));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One operation for one sampled edge, then hold until it has settled
  task automatic run_row(input usr_row_t w);
    @(posedge clock);
    {hi, lo, clr_n, sr, sl, eb_n, ea_n, drv} <= w[23:16];
    drv_data <= w.v;
    @(posedge clock);
    {hi, lo, clr_n, drv} <= 4'h2;
    repeat (4) @(posedge clock);
  endtask

  // Write: both channels offered together, each dropped once taken
  // Waits as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] x,
                        input logic [1:0] xr);
    @(posedge clock);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check("rdata", rdata, x);
    check("rresp", 32'(rresp), 32'(xr));
    rready <= 1'b0;
  endtask

  // Watchdog well beyond the roughly 120 cycles the tests need
  initial begin
    #20000;
    miscompares++;
    close_out;
  end

  initial begin
    {lo, hi, sr, sl, drv, awvalid, wvalid, bready, arvalid, rready} = '0;
    {clr_n, ea_n, eb_n, rst} = 4'hf;
    {awaddr, araddr, wdata, drv_data} = '0;
    strb = 4'hf;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    check("rst_word", 32'(dev_q), 32'h0);
    rd_chk(`USR_OFF_COUNT_CTRL, 32'he, `USR_RESP_OKAY);
    rd_chk(`USR_OFF_OPCOUNT, 32'h0, `USR_RESP_OKAY);
    rd_chk(`USR_OFF_STATUS, 32'h30, `USR_RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      run_row(rows[i]);
      check("word", 32'(dev_q), 32'(rows[i].x));
      check("ends", {q7, q0}, {rows[i].x[7], rows[i].x[0]});
      check("drive", 32'(dev_oe), 32'({8{rows[i].e == 2'h0}}));
      if (rows[i].e == 2'h0) check("wire", 32'(bus), 32'(rows[i].x));
    end
    // Load with drivers on: host waits for them to let go first
    @(posedge clock);
    {hi, lo} <= 2'h3;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (dev_oe !== 8'h00 && n < 10);
    check("drv_off", 32'(dev_oe), 32'h0);
    drv <= 1'b1;
    drv_data <= 8'h3c;
    repeat (3) @(posedge clock);
    {hi, lo, drv} <= 3'h0;
    repeat (4) @(posedge clock);
    check("load", 32'(dev_q), 32'h3c);
    check("wire", 32'(bus), 32'h3c);
    // Count shifts, then prove a shift adds one to a value written to the counter
    axi_wr(`USR_OFF_COUNT_CTRL, 32'h5);
    axi_wr(`USR_OFF_OPCOUNT, 32'h12345678);
    check("bresp", 32'(resp), 32'(`USR_RESP_OKAY));
    run_row(24'h700079);
    check("shift", 32'(dev_q), 32'h79);
    rd_chk(`USR_OFF_OPCOUNT, 32'h12345679, `USR_RESP_OKAY);
    // Only the strobed byte lane of the counter may change
    strb <= 4'h2;
    axi_wr(`USR_OFF_OPCOUNT, 32'h0000ab00);
    rd_chk(`USR_OFF_OPCOUNT, 32'h1234ab79, `USR_RESP_OKAY);
    strb <= 4'hf;
    axi_wr(`USR_OFF_STATE, 32'hff);
    check("bresp", 32'(resp), 32'(`USR_RESP_OKAY));
    rd_chk(`USR_OFF_STATE, 32'h79, `USR_RESP_OKAY);
    rd_chk(`USR_OFF_STATUS, 32'h8, `USR_RESP_OKAY);
    rd_chk(4'h2, 32'h0, `USR_RESP_SLVERR);
    axi_wr(4'h2, 32'h1);
    check("bresp_bad", 32'(resp), 32'(`USR_RESP_SLVERR));
    close_out;
  end
endmodule // tb_usr_shift_register
